// ===== drb_defines.svh
`ifndef DRB_DEFINES_SVH
`define DRB_DEFINES_SVH

// one-hot codes of the output stage modes
`define DRB_MODE_BYPASS 4'h1
`define DRB_MODE_SDR    4'h2
`define DRB_MODE_DDR    4'h4
`define DRB_MODE_GEAR   4'h8

// last fast-clock slot of one fabric period
`define DRB_LAST_DDR    2'h1
`define DRB_LAST_GEAR   2'h3

// first slot of a fabric period, where capture results appear
`define DRB_SLOT_FIRST  2'h0
// second slot of a fabric period
`define DRB_SLOT_SECOND 2'h1

// reset values
`define DRB_RST_BIT     1'h0
`define DRB_RST_CNT     2'h0
`define DRB_RST_GEAR    4'h0

`endif

// ===== drb_fabric_model.sv
`timescale 1ns/1ps
// fabric side: fresh random data every cycle, so only captured values can match
module drb_fabric_model (
    input  wire logic  clock_i,  // fabric clock
    output logic       first_o,  // first fabric data
    output logic       second_o, // second fabric data
    output logic [3:0] gear_o    // gearbox streams a0, a1, b0, b1
);
    initial {first_o, second_o, gear_o} = 6'h00;
    // change just after the falling edge, well away from any capture edge
    always @(negedge clock_i) {first_o, second_o, gear_o} <= 6'($urandom);
endmodule

// ===== drb_output_block.sv
`timescale 1ns/1ps
`include "drb_defines.svh"

// Overview of operation
// - optional register stage before pad buffer
// - sdr registers plus extra latch for ddr
// - sdr: first data through one element
// - sdr element is flip-flop or latch
// - ddr: capture both inputs on capture edge
// - ddr: second value held next cycle
// - selector sends both values each period
// - gearbox accepts four parallel streams
module drb_output_block
    import drb_pkg::*;
(
    input  wire logic clock_i,             // fast clock, 200 MHz
    input  wire logic rst_b_i,             // synchronous reset, active low
    input  wire logic bypass_i,            // register stage left out
    input  wire logic ddr_mode_i,          // double data rate selected
    input  wire logic gearbox_mode_i,      // four-stream gearbox selected
    input  wire logic latch_mode_i,        // sdr element acts as a latch
    input  wire logic first_fabric_data_i, // first data from fabric
    input  wire logic second_fabric_data_i,// second data from fabric
    input  wire logic gearbox_stream_a0_i, // gearbox stream, slot 0
    input  wire logic gearbox_stream_a1_i, // gearbox stream, slot 1
    input  wire logic gearbox_stream_b0_i, // gearbox stream, slot 2
    input  wire logic gearbox_stream_b1_i, // gearbox stream, slot 3
    output logic      pad_output_data_o,   // data towards the pad buffer
    output logic      fabric_strobe_o      // fabric data taken at next edge
);

    drb_state_t st_ff;   // registered state
    drb_state_t nxt_st;  // next state
    logic [1:0] last;    // last slot of the current period
    logic [1:0] nxt_last;// last slot of the next period
    logic       cap;     // capture edge of the fabric rate
    drb_mode_t  sel_mode;// mode requested by the mode inputs

    // mode decode: bypass wins, then gearbox, then ddr, else sdr
    always_comb begin
        if (bypass_i) begin
            sel_mode = MODE_BYPASS;
        end else if (gearbox_mode_i) begin
            sel_mode = MODE_GEAR;
        end else if (ddr_mode_i) begin
            sel_mode = MODE_DDR;
        end else begin
            sel_mode = MODE_SDR;
        end
    end

    // next-state logic for the whole block
    always_comb begin
        nxt_st = st_ff;
        // gearbox needs four slots per fabric period, others two
        last = (st_ff.mode == MODE_GEAR) ? `DRB_LAST_GEAR : `DRB_LAST_DDR;
        cap  = (st_ff.cnt == last);
        if (cap) begin
            // modes change only on a period boundary so a period never mixes modes
            nxt_st.cnt     = `DRB_SLOT_FIRST;
            nxt_st.mode    = sel_mode;
            nxt_st.latch   = latch_mode_i;
            nxt_st.neg_cap = first_fabric_data_i;
            nxt_st.pos_cap = second_fabric_data_i;
            // borrowed capture registers take the four streams together
            nxt_st.gear    = {gearbox_stream_b1_i, gearbox_stream_b0_i,
                              gearbox_stream_a1_i, gearbox_stream_a0_i};
            if (!latch_mode_i) begin
                nxt_st.sdr = first_fabric_data_i;  // flip-flop samples on the edge
            end
        end else begin
            nxt_st.cnt = st_ff.cnt + 2'h1;
        end
        // latch is transparent through the first slot, opaque otherwise
        if (st_ff.latch && (st_ff.cnt == `DRB_SLOT_FIRST)) begin
            nxt_st.sdr = first_fabric_data_i;
        end
        // extra latch: hold the second value over the following slot
        if (st_ff.cnt == `DRB_SLOT_FIRST) begin
            nxt_st.pos_hold = st_ff.pos_cap;
        end
        // strobe is registered so the fabric sees a clean enable
        nxt_last      = (nxt_st.mode == MODE_GEAR) ? `DRB_LAST_GEAR : `DRB_LAST_DDR;
        nxt_st.strobe = (nxt_st.cnt == nxt_last);
        // output selector, switched by the mode and, in ddr and gearbox, by the slot counter
        case (st_ff.mode)
            MODE_BYPASS: begin
                nxt_st.pad = first_fabric_data_i;  // stage left out, one pipeline flop only
            end
            MODE_SDR: begin
                nxt_st.pad = st_ff.sdr;
            end
            MODE_DDR: begin
                // first value in slot 0, held second value in slot 1
                nxt_st.pad = (st_ff.cnt == `DRB_SLOT_FIRST) ? st_ff.neg_cap
                                                            : st_ff.pos_hold;
            end
            MODE_GEAR: begin
                nxt_st.pad = st_ff.gear[st_ff.cnt];
            end
            default: begin
                nxt_st.pad = `DRB_RST_BIT;
            end
        endcase
    end

    // state register with synchronous reset
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            st_ff <= '{mode: MODE_SDR, latch: `DRB_RST_BIT, cnt: `DRB_RST_CNT,
                       strobe: `DRB_RST_BIT, sdr: `DRB_RST_BIT, neg_cap: `DRB_RST_BIT,
                       pos_cap: `DRB_RST_BIT, pos_hold: `DRB_RST_BIT,
                       gear: `DRB_RST_GEAR, pad: `DRB_RST_BIT};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs come straight from the state flops
    assign pad_output_data_o = st_ff.pad;
    assign fabric_strobe_o   = st_ff.strobe;

    // bypass: pad follows first data one cycle later
    bypass_path_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (st_ff.mode == MODE_BYPASS) |=> (pad_output_data_o == $past(first_fabric_data_i)))
        else $error("bypass path does not follow first data");

    // sdr flip-flop: value taken at the capture edge reaches the pad
    sdr_flop_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        // only right after a real capture: the first slot after reset holds the reset value
        (st_ff.mode == MODE_SDR && !st_ff.latch && st_ff.cnt == `DRB_SLOT_FIRST && $past(st_ff.strobe))
        |=> (pad_output_data_o == $past(first_fabric_data_i, 2)))
        else $error("sdr flip-flop output wrong");

    // sdr latch: value at the end of the open slot reaches the pad
    sdr_latch_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (st_ff.mode == MODE_SDR && st_ff.latch && st_ff.cnt == `DRB_SLOT_SECOND)
        |=> (pad_output_data_o == $past(first_fabric_data_i, 2)))
        else $error("sdr latch output wrong");

    // ddr: both inputs captured together
    ddr_capture_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (st_ff.mode == MODE_DDR && st_ff.cnt == `DRB_SLOT_FIRST)
        |-> (st_ff.neg_cap == $past(first_fabric_data_i))
            && (st_ff.pos_cap == $past(second_fabric_data_i)))
        else $error("ddr capture registers wrong");

    // ddr: held copy of second data in the following slot
    ddr_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (st_ff.mode == MODE_DDR && st_ff.cnt == `DRB_SLOT_SECOND)
        |-> (st_ff.pos_hold == $past(second_fabric_data_i, 2)))
        else $error("ddr hold latch wrong");

    // ddr: first value on the pad in the first output slot
    ddr_first_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (st_ff.mode == MODE_DDR && st_ff.cnt == `DRB_SLOT_FIRST)
        |=> (pad_output_data_o == $past(first_fabric_data_i, 2)))
        else $error("ddr first value missing on pad");

    // ddr: second value follows in the next output slot
    ddr_second_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (st_ff.mode == MODE_DDR && st_ff.cnt == `DRB_SLOT_FIRST)
        |=> ##1 (pad_output_data_o == $past(second_fabric_data_i, 3)))
        else $error("ddr second value missing on pad");

    // gearbox: four streams leave in order a0, a1, b0, b1
    gear_order_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (st_ff.mode == MODE_GEAR && st_ff.cnt == `DRB_SLOT_FIRST)
        |=> (pad_output_data_o == $past(gearbox_stream_a0_i, 2))
            ##1 (pad_output_data_o == $past(gearbox_stream_a1_i, 3))
            ##1 (pad_output_data_o == $past(gearbox_stream_b0_i, 4))
            ##1 (pad_output_data_o == $past(gearbox_stream_b1_i, 5)))
        else $error("gearbox stream order wrong");

    // strobe is a single-cycle pulse; a wider one would let the fabric
    // advance twice within one period and lose a data word
    strobe_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        fabric_strobe_o |=> !fabric_strobe_o)
        else $error("fabric strobe wider than one cycle");

    // two-slot modes: the next capture edge comes one slot after the first slot
    // so both captured values leave within one fabric period
    short_period_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ($past(st_ff.strobe) && st_ff.mode != MODE_GEAR)
        |-> !st_ff.strobe ##1 st_ff.strobe)
        else $error("two-slot fabric period wrong");

    // gearbox: four slots per fabric period, strobe only in the last one
    // so each of the four streams gets exactly one pad slot
    gear_period_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ($past(st_ff.strobe) && st_ff.mode == MODE_GEAR)
        |-> !st_ff.strobe ##1 !st_ff.strobe ##1 !st_ff.strobe ##1 st_ff.strobe)
        else $error("gearbox fabric period wrong");

    // mode and latch selection move only on a capture edge; a change inside
    // a period would mix two selector patterns on the pad
    mode_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !st_ff.strobe |=> ($stable(st_ff.mode) && $stable(st_ff.latch)))
        else $error("mode changed inside a fabric period");

    // gearbox: the borrowed registers take all four streams at the capture edge
    // together, so the pad order never depends on when the fabric settles
    gear_capture_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ($past(st_ff.strobe) && st_ff.mode == MODE_GEAR)
        |-> (st_ff.gear == {$past(gearbox_stream_b1_i), $past(gearbox_stream_b0_i),
                            $past(gearbox_stream_a1_i), $past(gearbox_stream_a0_i)}))
        else $error("gearbox capture registers wrong");

    // sdr flip-flop: the pad value stands for the whole fabric period
    // the latch variant is left out here, it opens in the first slot
    sdr_stand_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (st_ff.mode == MODE_SDR && !st_ff.latch && st_ff.cnt == `DRB_SLOT_SECOND)
        |=> $stable(pad_output_data_o))
        else $error("sdr pad value did not stand for the period");

    // reset: pad and strobe are quiet one edge after reset is seen
    // so the pad buffer never launches stale data after a restart
    pad_reset_a: assert property (@(posedge clock_i)
        !rst_b_i |=> (pad_output_data_o == `DRB_RST_BIT && fabric_strobe_o == `DRB_RST_BIT))
        else $error("outputs not cleared by reset");

endmodule

// ===== drb_output_block_test.sv
`timescale 1ns/1ps
module drb_output_block_test;
    import drb_pkg::*;
    logic       clock_i = 1'b0; // 200 MHz clock
    logic       rst_b_i = 1'b0; // reset, active low
    logic [3:0] md      = 4'h0; // bypass, gearbox, ddr, latch requests
    logic       f, s, pad, stb; // fabric data and design outputs
    logic [3:0] g;              // gearbox streams
    int         n_fail = 0, total_checks = 0, cyc = 0, gap = 0, want = -1, hold = 0, pend = 0;
    int         q[5];           // expected pad after each coming edge, -1 unknown
    drb_mode_t  m_mode, c;      // mode taken at the last capture edge
    logic [3:0] modes[8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h2, 4'h0};

    drb_fabric_model i_fab (.clock_i(clock_i), .first_o(f), .second_o(s), .gear_o(g));
    drb_output_block i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .bypass_i(md[3]), .gearbox_mode_i(md[2]),
        .ddr_mode_i(md[1]), .latch_mode_i(md[0]), .first_fabric_data_i(f), .second_fabric_data_i(s),
        .gearbox_stream_a0_i(g[0]), .gearbox_stream_a1_i(g[1]), .gearbox_stream_b0_i(g[2]),
        .gearbox_stream_b1_i(g[3]), .pad_output_data_o(pad), .fabric_strobe_o(stb));

    initial forever #2.5 clock_i = ~clock_i;

    task automatic stop_test();
        $display("TB: checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk_pad(input logic a, input logic e);
        total_checks++;
        if (a !== e) begin
            n_fail++;
            $display("[ERR] %0t pad %b expected %b", $time, a, e);
        end
    endtask

    task automatic chk_gap(input int a, input int e);
        total_checks++;
        if (a != e) begin
            n_fail++;
            $display("[ERR] %0t strobe spacing %0d expected %0d", $time, a, e);
        end
    endtask

    // reference model; it reads values before the edge lands, so no race with the design
    always @(posedge clock_i) begin
        if (want >= 0) chk_pad(pad, want[0]);
        if (!rst_b_i) begin
            q = '{default: -1};
            want = 0;
            hold = 0;
            pend = 0;
            gap = -9;
            m_mode = MODE_SDR;
        end else begin
            if (pend != 0) q[1] = f; // latch closes at the end of slot 0, pad shows it one edge later
            pend = 0;
            want = (m_mode == MODE_BYPASS) ? f : (q[0] >= 0) ? q[0] : hold;
            hold = want;
            q = '{q[1], q[2], q[3], q[4], -1};
            gap++;
            if (stb === 1'b1) begin
                if (gap > 0) chk_gap(gap, (m_mode == MODE_GEAR) ? 4 : 2);
                gap = 0;
                c = md[3] ? MODE_BYPASS : md[2] ? MODE_GEAR : md[1] ? MODE_DDR : MODE_SDR;
                if (c == MODE_SDR) begin
                    if (md[0]) pend = 1;
                    else q[0] = f;
                end
                if (c == MODE_DDR) begin
                    q[0] = f;
                    q[1] = s;
                end
                if (c == MODE_GEAR) begin
                    q[0] = g[0];
                    q[1] = g[1];
                    q[2] = g[2];
                    q[3] = g[3];
                end
                m_mode = c;
            end
        end
    end

    // a hang is cut short well past the expected run length
    always @(posedge clock_i) if (++cyc == 2000) begin
        n_fail++;
        stop_test();
    end

    // modes change mid-period on purpose: they may only take effect at a capture edge
    initial begin
        void'($urandom(33));
        repeat (20) @(negedge clock_i);
        rst_b_i = 1'b1;
        foreach (modes[i]) begin
            md = modes[i];
            repeat (41) @(negedge clock_i);
            if (i == 5) rst_b_i = 1'b0;
            repeat (3) @(negedge clock_i);
            rst_b_i = 1'b1;
            $display("TB: test %0d mode %h done", i, modes[i]);
        end
        stop_test();
    end
endmodule

// ===== drb_pkg.sv
`include "drb_defines.svh"

package drb_pkg;

    // output stage mode, one-hot
    typedef enum logic [3:0] {
        MODE_BYPASS = `DRB_MODE_BYPASS,
        MODE_SDR    = `DRB_MODE_SDR,
        MODE_DDR    = `DRB_MODE_DDR,
        MODE_GEAR   = `DRB_MODE_GEAR
    } drb_mode_t;

    // all state of the output register block
    typedef struct packed {
        drb_mode_t   mode;     // mode taken at the last capture edge
        logic        latch;    // sdr element acts as a latch
        logic [1:0]  cnt;      // fast-clock slot inside the fabric period
        logic        strobe;   // fabric capture enable, high in the last slot
        logic        sdr;      // sdr storage element
        logic        neg_cap;  // captured first fabric data
        logic        pos_cap;  // captured second fabric data
        logic        pos_hold; // second value held for the following slot
        logic [3:0]  gear;     // four gearbox streams
        logic        pad;      // pad output data
    } drb_state_t;

endpackage
